// ### dv/spi_fifo_transfer_control_tb.sv
// Self-checking bench for the serial port transfer control block.
`timescale 1ns/100ps
`default_nettype none
module spi_fifo_transfer_control_tb;
   import spi_xfer_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   bus_req_t bus = '0;
   logic sclk = 1'b0;
   logic mosi = 1'b0;
   logic ss_n = 1'b1;
   logic [31:0] rd = 32'h0000_0000;
   logic [31:0] rdata;
   logic irq, m_sclk, m_mosi, m_ss_n, miso, miso_oe, s_miso;
   logic mosi_oe, ss_oe;
   logic [7:0] got;
   int miscompares = 0;
   int cmp_count = 0;
   int cycles = 0;
   always #5 clk = ~clk;
   spi_fifo_transfer_control u_dut (.i_sys_clk(clk), .i_reset(rst),
      .i_bus(bus), .o_rdata(rdata), .o_irq(irq), .i_sclk(sclk),
      .i_mosi(mosi), .i_miso(s_miso), .i_ss_n(ss_n), .o_sclk(m_sclk),
      .o_sclk_oe(), .o_mosi(m_mosi), .o_mosi_oe(mosi_oe), .o_miso(miso),
      .o_miso_oe(miso_oe), .o_ss_n(m_ss_n), .o_ss_oe(ss_oe));
   spi_slave_model u_slave (.i_sclk(m_sclk), .i_mosi(m_mosi),
      .i_ss_n(m_ss_n), .i_reply(8'h3C), .o_miso(s_miso), .o_got(got));
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] seen);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         print_verdict();
      end
   end
   task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge clk);
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      #1 rd = rdata;
   endtask
   // A short divider keeps each byte near seventy clocks.
   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      op(1, 8'h0C, 32'h0000_0003);
   endtask
   task automatic xfer_wait();
      int n;
      n = 0;
      while (m_ss_n !== 1'b0 && n < 300) begin
         @(posedge clk);
         #1;
         n++;
      end
      while (m_ss_n !== 1'b1 && n < 900) begin
         @(posedge clk);
         #1;
         n++;
      end
      // Leaves room for the receive push and the idle gap.
      repeat (10) @(posedge clk);
      chk("transfer end", 1, n < 900);
   endtask
   task automatic t_regs();
      op(0, 8'h10, 0);
      chk("control reset", 0, rd);
      op(0, 8'h0C, 0);
      chk("divider read", 0, rd);
      op(0, 8'h40, 0);
      chk("unmapped read", 0, rd);
   endtask
   task automatic t_thr();
      for (int t = 0; t < 4; t++) begin
         do_reset();
         op(1, 8'h14, 32'h0000_0002);
         op(1, 8'h10, {t[1:0], 14'h0043});
         chk("master oe on", 3, {mosi_oe, ss_oe});
         for (int k = 0; k <= t; k++) begin
            op(1, 8'h08, 32'h0000_00A0 + k);
            xfer_wait();
            chk("tx irq", k == t, irq);
         end
         chk("slave got", 32'h0000_00A0 + t, got);
         op(0, 8'h04, 0);
         chk("rx byte", 32'h0000_003C, rd);
         op(1, 8'h18, 32'h0000_0002);
         chk("irq cleared", 0, irq);
      end
   endtask
   task automatic t_purge();
      do_reset();
      op(1, 8'h14, 32'h0000_000F);
      op(1, 8'h10, 32'h0000_0083);
      op(1, 8'h08, 32'h0000_0011);
      op(1, 8'h08, 32'h0000_0022);
      op(0, 8'h00, 0);
      chk("tx count", 2, rd[3:1]);
      op(1, 8'h10, 32'h0000_3083);
      op(0, 8'h00, 0);
      chk("tx purged", 0, rd[3:1]);
      op(1, 8'h08, 32'h0000_0077);
      op(0, 8'h00, 0);
      chk("tx locked", 0, rd[3:1]);
      op(0, 8'h04, 0);
      xfer_wait();
      chk("purge fill", 0, got);
      op(0, 8'h00, 0);
      chk("rx purged", 0, rd[10:8]);
      chk("purge irq", 0, irq);
      op(1, 8'h10, 32'h0000_0003);
      op(1, 8'h08, 32'h0000_0096);
      op(0, 8'h04, 0);
      xfer_wait();
      chk("sent byte", 32'h0000_0096, got);
      op(0, 8'h04, 0);
      chk("rx byte", 32'h0000_003C, rd);
      xfer_wait();
      chk("resend last", 32'h0000_0096, got);
   endtask
   task automatic t_ovf();
      for (int ow = 0; ow < 2; ow++) begin
         do_reset();
         op(1, 8'h14, 32'h0000_0004);
         op(1, 8'h10, 32'h0000_0443 | (ow << 8));
         for (int i = 0; i < 5; i++) begin
            op(1, 8'h08, 32'h0000_0050 + i);
            xfer_wait();
         end
         chk("ovf irq", 1, irq);
         op(0, 8'h00, 0);
         chk("ovf flag", 1, rd[7]);
         op(0, 8'h00, 0);
         chk("ovf cleared", 0, rd[7]);
         for (int i = 0; i < 4; i++) begin
            op(0, 8'h04, 0);
            chk("loop byte", (i == 3 && ow == 1) ? 32'h0000_0054 :
                32'h0000_0050 + i, rd);
         end
      end
   endtask
   task automatic t_cont();
      int rises;
      logic prev;
      for (int c = 0; c < 2; c++) begin
         do_reset();
         op(1, 8'h10, 32'h0000_0043 | (c << 11));
         op(1, 8'h08, 32'h0000_0001);
         op(1, 8'h08, 32'h0000_0002);
         rises = 0;
         prev = 1'b1;
         repeat (400) begin
            @(posedge clk);
            #1;
            if (m_ss_n === 1'b1 && prev === 1'b0) rises++;
            prev = m_ss_n;
         end
         chk("select releases", c ? 1 : 2, rises);
      end
   endtask
   // The link clock runs at 160 ns and only inside the frame.
   task automatic t_slave();
      logic [7:0] b;
      b = 8'hC3;
      for (int d = 0; d < 2; d++) begin
         do_reset();
         op(1, 8'h10, 32'h0000_0001 | (d << 9));
         op(1, 8'h08, 32'h0000_0080);
         @(posedge clk);
         ss_n <= 1'b0;
         repeat (8) @(posedge clk);
         #1 chk("slave drive", d, miso_oe);
         chk("slave first bit", 1, miso);
         chk("master oe off", 0, {mosi_oe, ss_oe});
         for (int i = 7; i >= 0; i--) begin
            mosi <= b[i];
            repeat (8) @(posedge clk);
            sclk <= 1'b1;
            repeat (8) @(posedge clk);
            sclk <= 1'b0;
         end
         ss_n <= 1'b1;
         mosi <= ~b[0];
         repeat (8) @(posedge clk);
         op(0, 8'h04, 0);
         chk("slave rx", 32'h0000_00C3, rd);
      end
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_thr();
      t_purge();
      t_ovf();
      t_cont();
      t_slave();
      print_verdict();
   end
endmodule
`default_nettype wire

// ### dv/spi_slave_model.sv
// Behavioural serial slave that answers the block in master mode.
`timescale 1ns/100ps
`default_nettype none
module spi_slave_model (
   input wire logic i_sclk,
   input wire logic i_mosi,
   input wire logic i_ss_n,
   input wire logic [7:0] i_reply,
   output logic o_miso,
   output logic [7:0] o_got
);
   logic [7:0] shift_reg = 8'h00;
   initial begin
      o_miso = 1'b0;
      o_got = 8'h00;
   end
   // Mode 0 needs the first bit on the line as soon as select falls.
   always @(negedge i_ss_n) begin
      shift_reg = i_reply;
      o_miso = shift_reg[7];
   end
   always @(posedge i_sclk) begin
      if (!i_ss_n) o_got = {o_got[6:0], i_mosi};
   end
   always @(negedge i_sclk) begin
      if (!i_ss_n) begin
         shift_reg = {shift_reg[6:0], 1'b0};
         o_miso = shift_reg[7];
      end
   end
   // A released line must not keep showing its last bit.
   always @(posedge i_ss_n) begin
      o_miso = ~o_miso;
   end
endmodule
`default_nettype wire

// ### dv/spi_xfer_assertions.sv
// Port-level assertions for the serial port transfer control block.
`timescale 1ns/100ps
`default_nettype none
module spi_xfer_assertions
   import spi_xfer_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire bus_req_t i_bus,
   input wire logic [31:0] o_rdata,
   input wire logic o_irq,
   input wire logic o_sclk,
   input wire logic o_sclk_oe,
   input wire logic o_miso,
   input wire logic o_miso_oe,
   input wire logic o_ss_n
);
   logic [15:0] ctl_reg;
   logic [7:0] div_reg;
   logic [3:0] mask_reg;
   logic [5:0] rise_reg;
   logic [9:0] gap_reg;
   logic sclk_reg;
   logic ss_reg;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   // The checker sees no registers, so settings are shadowed off the bus.
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         ctl_reg <= 16'h0000;
         div_reg <= 8'h1B;
         mask_reg <= 4'h0;
      end else if (i_bus.wr) begin
         if (i_bus.addr == 8'h10) ctl_reg <= i_bus.wdata[15:0];
         if (i_bus.addr == 8'h0C) div_reg <= i_bus.wdata[7:0];
         if (i_bus.addr == 8'h14) mask_reg <= i_bus.wdata[3:0];
      end
   end
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         sclk_reg <= 1'b0;
         ss_reg <= 1'b1;
         rise_reg <= 6'h00;
         gap_reg <= 10'h3FF;
      end else begin
         sclk_reg <= o_sclk;
         ss_reg <= o_ss_n;
         if (ss_reg && !o_ss_n) rise_reg <= 6'h00;
         else if (o_sclk && !sclk_reg) rise_reg <= rise_reg + 6'h01;
         if (!ss_reg && o_ss_n) gap_reg <= 10'h000;
         else if (o_ss_n && gap_reg != 10'h3FF) gap_reg <= gap_reg + 10'h001;
      end
   end
   a_ctl_readback:
      assert property (i_bus.rd && i_bus.addr == 8'h10 |=>
         o_rdata == {16'h0000, $past(ctl_reg)})
      else $error("control read data wrong");
   a_master_drive:
      assert property (ctl_reg[1:0] == 2'h3 && $past(ctl_reg[1:0], 2) == 2'h3
         |-> o_sclk_oe)
      else $error("master clock not driven");
   a_loop_quiet:
      assert property (ctl_reg[10] && $past(ctl_reg[10], 2) |-> !o_miso_oe)
      else $error("slave data driven in loopback");
   a_open_drain:
      assert property (o_miso_oe && !ctl_reg[9] && !$past(ctl_reg[9], 2)
         |-> !o_miso)
      else $error("slave data driven high with drive off");
   a_irq_masked:
      assert property (mask_reg == 4'h0 && $past(mask_reg) == 4'h0 |-> !o_irq)
      else $error("interrupt with all sources masked");
   a_single_byte:
      assert property ($rose(o_ss_n) && !ctl_reg[11] |-> rise_reg == 6'h08)
      else $error("single transfer not eight clocks");
   a_cont_whole:
      assert property ($rose(o_ss_n) && ctl_reg[11] |->
         rise_reg[2:0] == 3'h0 && rise_reg != 6'h00)
      else $error("continuous frame not whole bytes");
   a_gap_len:
      assert property ($fell(o_ss_n) && !ctl_reg[11] |->
         gap_reg >= {1'b0, div_reg, 1'b0})
      else $error("idle gap shorter than one serial clock");
endmodule
bind spi_fifo_transfer_control spi_xfer_assertions u_chk (
   .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_bus(i_bus),
   .o_rdata(o_rdata), .o_irq(o_irq), .o_sclk(o_sclk),
   .o_sclk_oe(o_sclk_oe), .o_miso(o_miso), .o_miso_oe(o_miso_oe),
   .o_ss_n(o_ss_n));
`default_nettype wire

// ### hdl/spi_fifo_transfer_control.sv
// Serial port with 4-byte FIFOs, transfer control and interrupt logic.
// Operation
// - Threshold code n: tx irq after n+1 sent with trigger set, rx irq at n+1 stored with trigger clear.
// - Transmit purge empties the transmit FIFO; software clears it again.
// - While transmit purge holds, send last byte or zero per fill setting.
// - Writes to transmit data are ignored while transmit purge is set.
// - Receive purge empties the receive FIFO; software clears it again.
// - While receive purge holds, received bytes dropped, no interrupts.
// - Receive purge with read trigger: receive read starts a transfer.
// - Continuous master mode keeps select low while transmit data remains.
// - Single mode: one byte, then one serial clock idle gap.
// - Loopback routes serial output straight back to serial input.
// - Slave output drive off makes the slave data pin open drain.
// - Overwrite set and receive FIFO full: newest slot gets new byte.
// - Overwrite clear and receive FIFO full: new byte discarded.
// - A control bit selects the byte sent when transmit FIFO empty.
// - Fill bit set sends zero, clear resends last transmitted byte.
// - Trigger set: write starts transfer; clear: receive read starts it.
// - Overflow flag set on full receive, interrupts, cleared on read.
// - Master select bit chooses master or slave operation.
`timescale 1ns/100ps
`default_nettype none
`include "spi_xfer_defines.svh"
module spi_fifo_transfer_control
   import spi_xfer_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire bus_req_t i_bus,
   output logic [31:0] o_rdata,
   output logic o_irq,
   input wire logic i_sclk,
   input wire logic i_mosi,
   input wire logic i_miso,
   input wire logic i_ss_n,
   output logic o_sclk,
   output logic o_sclk_oe,
   output logic o_mosi,
   output logic o_mosi_oe,
   output logic o_miso,
   output logic o_miso_oe,
   output logic o_ss_n,
   output logic o_ss_oe
);
   logic [15:0] serial_port_control_reg;
   logic [7:0] divider_reg;
   logic [3:0] irq_mask_reg;
   logic [3:0] irq_status_reg;
   logic rx_overflow_flag_reg;
   logic read_pend_reg;
   logic [7:0] tx_mem [0:3];
   logic [7:0] rx_mem [0:3];
   logic [1:0] tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
   logic [2:0] tx_cnt_reg, rx_cnt_reg;
   logic [7:0] tx_sh_reg, rx_sh_reg, last_tx_reg;
   logic [2:0] bit_cnt_reg;
   logic [2:0] sent_cnt_reg;
   master_state_t state_reg;
   logic [7:0] div_cnt_reg;
   logic gap_half_reg;
   logic sclk_reg, ss_n_reg;
   logic [2:0] sclk_s, mosi_s, ss_s;
   logic [1:0] miso_s;

   wire logic [1:0] thr = serial_port_control_reg[`CTL_THR_HI:`CTL_THR_LO];
   wire logic tx_purge = serial_port_control_reg[`CTL_TX_PURGE];
   wire logic rx_purge = serial_port_control_reg[`CTL_RX_PURGE];
   wire logic cont_en = serial_port_control_reg[`CTL_CONT];
   wire logic loop_en = serial_port_control_reg[`CTL_LOOP];
   wire logic sout_en = serial_port_control_reg[`CTL_SOUT_EN];
   wire logic overwrite = serial_port_control_reg[`CTL_OVERWRITE];
   wire logic fill_zero = serial_port_control_reg[`CTL_FILL_ZERO];
   wire logic trig_sel = serial_port_control_reg[`CTL_TRIG_SEL];
   wire logic master = serial_port_control_reg[`CTL_MASTER];
   wire logic enable = serial_port_control_reg[`CTL_ENABLE];
   wire logic [2:0] thr_cnt = {1'b0, thr} + 3'h1;

   wire logic wr_tx = i_bus.wr && i_bus.addr == `OFS_TX_DATA;
   wire logic rd_rx = i_bus.rd && i_bus.addr == `OFS_RX_DATA;
   wire logic rd_st = i_bus.rd && i_bus.addr == `OFS_STATUS;
   wire logic tx_empty = tx_cnt_reg == 3'h0;
   wire logic tx_full = tx_cnt_reg == `FIFO_DEPTH;
   wire logic rx_empty = rx_cnt_reg == 3'h0;
   wire logic rx_full = rx_cnt_reg == `FIFO_DEPTH;

   // Pin synchronisers; only the second stage onward is read.
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         sclk_s <= 3'h0;
         mosi_s <= 3'h0;
         ss_s <= 3'h7;
         miso_s <= 2'h0;
      end else begin
         sclk_s <= {sclk_s[1:0], i_sclk};
         mosi_s <= {mosi_s[1:0], i_mosi};
         ss_s <= {ss_s[1:0], i_ss_n};
         miso_s <= {miso_s[0], i_miso};
      end
   end

   // Master timing: one tick per half serial clock period.
   wire logic tick = div_cnt_reg == divider_reg;
   wire logic m_act = enable && master;
   wire logic s_act = enable && !master && !ss_s[1];
   wire logic m_start = m_act && state_reg == ST_IDLE
      && (trig_sel ? !tx_empty : read_pend_reg);
   wire logic m_rise = state_reg == ST_XFER && tick && !sclk_reg;
   wire logic m_fall = state_reg == ST_XFER && tick && sclk_reg;
   wire logic m_next = m_fall && bit_cnt_reg == 3'h0 && cont_en && !tx_empty;
   wire logic s_rise = s_act && sclk_s[1] && !sclk_s[2];
   wire logic s_fall = s_act && !sclk_s[1] && sclk_s[2];
   wire logic s_sel = enable && !master && !ss_s[1] && ss_s[2];

   wire logic load = master ? (m_start || m_next)
      : (s_sel || (s_fall && bit_cnt_reg == 3'h0));
   wire logic sample = master ? m_rise : s_rise;
   wire logic shift = master ? (m_fall && bit_cnt_reg != 3'h0)
      : (s_fall && bit_cnt_reg != 3'h0);
   wire logic done = sample && bit_cnt_reg == `BIT_LAST;
   wire logic ser_in = loop_en ? tx_sh_reg[7]
      : (master ? miso_s[1] : mosi_s[1]);
   wire logic [7:0] rx_byte = {rx_sh_reg[6:0], ser_in};
   wire logic tx_pop = load && !tx_empty && !tx_purge;
   wire logic underflow = load && (tx_empty || tx_purge);
   wire logic rx_push = done && !rx_purge && !rx_full;
   wire logic rx_pop = rd_rx && !rx_empty && !rx_purge;

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         serial_port_control_reg <= `CTL_RESET;
         divider_reg <= `DIV_RESET;
         irq_mask_reg <= 4'h0;
      end else if (i_bus.wr) begin
         if (i_bus.addr == `OFS_CONTROL) begin
            serial_port_control_reg <= i_bus.wdata[15:0];
         end
         if (i_bus.addr == `OFS_DIVIDER) begin
            divider_reg <= i_bus.wdata[7:0];
         end
         if (i_bus.addr == `OFS_IRQ_MASK) begin
            irq_mask_reg <= i_bus.wdata[3:0];
         end
      end
   end

   // Transmit FIFO.
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         tx_wp_reg <= 2'h0;
         tx_rp_reg <= 2'h0;
         tx_cnt_reg <= 3'h0;
      end else if (tx_purge) begin
         tx_wp_reg <= 2'h0;
         tx_rp_reg <= 2'h0;
         tx_cnt_reg <= 3'h0;
      end else begin
         if (wr_tx && !tx_full) begin
            tx_wp_reg <= tx_wp_reg + 2'h1;
         end
         if (tx_pop) begin
            tx_rp_reg <= tx_rp_reg + 2'h1;
         end
         if (wr_tx && !tx_full && !tx_pop) begin
            tx_cnt_reg <= tx_cnt_reg + 3'h1;
         end else if (tx_pop && !(wr_tx && !tx_full)) begin
            tx_cnt_reg <= tx_cnt_reg - 3'h1;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (wr_tx && !tx_full && !tx_purge) begin
         tx_mem[tx_wp_reg] <= i_bus.wdata[7:0];
      end
      if (rx_push) begin
         rx_mem[rx_wp_reg] <= rx_byte;
      end else if (done && !rx_purge && overwrite) begin
         rx_mem[rx_wp_reg - 2'h1] <= rx_byte;
      end
   end

   // Receive FIFO; a full FIFO without overwrite keeps its bytes.
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         rx_wp_reg <= 2'h0;
         rx_rp_reg <= 2'h0;
         rx_cnt_reg <= 3'h0;
      end else if (rx_purge) begin
         rx_wp_reg <= 2'h0;
         rx_rp_reg <= 2'h0;
         rx_cnt_reg <= 3'h0;
      end else begin
         if (rx_push) begin
            rx_wp_reg <= rx_wp_reg + 2'h1;
         end
         if (rx_pop) begin
            rx_rp_reg <= rx_rp_reg + 2'h1;
         end
         if (rx_push && !rx_pop) begin
            rx_cnt_reg <= rx_cnt_reg + 3'h1;
         end else if (rx_pop && !rx_push) begin
            rx_cnt_reg <= rx_cnt_reg - 3'h1;
         end
      end
   end

   // Shift registers and bit counter shared by master and slave.
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         tx_sh_reg <= `FILL_BYTE;
         rx_sh_reg <= 8'h00;
         last_tx_reg <= `FILL_BYTE;
         bit_cnt_reg <= 3'h0;
      end else begin
         if (load) begin
            if (tx_pop) begin
               tx_sh_reg <= tx_mem[tx_rp_reg];
               last_tx_reg <= tx_mem[tx_rp_reg];
            end else if (fill_zero) begin
               tx_sh_reg <= `FILL_BYTE;
            end else begin
               tx_sh_reg <= last_tx_reg;
            end
            bit_cnt_reg <= 3'h0;
         end else if (shift) begin
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
         end
         if (sample) begin
            rx_sh_reg <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
         end
         if (!enable || (!master && ss_s[1])) begin
            bit_cnt_reg <= 3'h0;
         end
      end
   end

   // Master sequencer.
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         state_reg <= ST_IDLE;
         sclk_reg <= 1'b0;
         ss_n_reg <= 1'b1;
         div_cnt_reg <= 8'h00;
         gap_half_reg <= 1'b0;
      end else if (!m_act) begin
         state_reg <= ST_IDLE;
         sclk_reg <= 1'b0;
         ss_n_reg <= 1'b1;
         div_cnt_reg <= 8'h00;
      end else begin
         div_cnt_reg <= (tick || state_reg == ST_IDLE) ? 8'h00
            : div_cnt_reg + 8'h01;
         case (state_reg)
            ST_IDLE: begin
               if (m_start) begin
                  state_reg <= ST_XFER;
                  ss_n_reg <= 1'b0;
               end
            end
            ST_XFER: begin
               if (m_rise) begin
                  sclk_reg <= 1'b1;
               end else if (m_fall) begin
                  sclk_reg <= 1'b0;
                  if (bit_cnt_reg == 3'h0 && !m_next) begin
                     ss_n_reg <= 1'b1;
                     state_reg <= cont_en ? ST_IDLE : ST_GAP;
                     gap_half_reg <= 1'b0;
                  end
               end
            end
            ST_GAP: begin
               if (tick) begin
                  gap_half_reg <= 1'b1;
                  if (gap_half_reg) begin
                     state_reg <= ST_IDLE;
                  end
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // A receive read arms one transfer in read-trigger mode.
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         read_pend_reg <= 1'b0;
      end else if (rd_rx && !trig_sel && m_act) begin
         read_pend_reg <= 1'b1;
      end else if (m_start || trig_sel || !m_act) begin
         read_pend_reg <= 1'b0;
      end
   end

   // Bytes sent since the last transmit interrupt.
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         sent_cnt_reg <= 3'h0;
      end else if (!trig_sel || tx_purge) begin
         sent_cnt_reg <= 3'h0;
      end else if (done) begin
         sent_cnt_reg <= (sent_cnt_reg + 3'h1 == thr_cnt) ? 3'h0
            : sent_cnt_reg + 3'h1;
      end
   end

   wire logic ev_tx = trig_sel && done && !tx_purge
      && sent_cnt_reg + 3'h1 == thr_cnt;
   wire logic ev_rx = !trig_sel && rx_push && rx_cnt_reg + 3'h1 == thr_cnt;
   wire logic ev_ovf = done && !rx_purge && rx_full;
   wire logic ev_unf = underflow && !tx_purge;
   wire logic [3:0] events = rx_purge ? 4'h0
      : {ev_unf, ev_ovf, ev_tx, ev_rx};

   // Sticky flags: a new event wins over a clear in the same cycle.
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         irq_status_reg <= 4'h0;
         rx_overflow_flag_reg <= 1'b0;
      end else begin
         if (i_bus.wr && i_bus.addr == `OFS_IRQ_STATUS) begin
            irq_status_reg <= (irq_status_reg & ~i_bus.wdata[3:0]) | events;
         end else begin
            irq_status_reg <= irq_status_reg | events;
         end
         if (ev_ovf) begin
            rx_overflow_flag_reg <= 1'b1;
         end else if (rd_st) begin
            rx_overflow_flag_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_bus.rd) begin
         case (i_bus.addr)
            `OFS_STATUS: o_rdata <= {20'h0_0000, rx_cnt_reg > thr_cnt,
               rx_cnt_reg, rx_overflow_flag_reg, irq_status_reg[`IRQ_RX],
               irq_status_reg[`IRQ_TX], irq_status_reg[`IRQ_UNF],
               tx_cnt_reg, o_irq};
            `OFS_RX_DATA: o_rdata <= {24'h00_0000,
               rx_empty ? 8'h00 : rx_mem[rx_rp_reg]};
            `OFS_CONTROL: o_rdata <= {16'h0000, serial_port_control_reg};
            `OFS_IRQ_MASK: o_rdata <= {28'h000_0000, irq_mask_reg};
            `OFS_IRQ_STATUS: o_rdata <= {28'h000_0000, irq_status_reg};
            default: o_rdata <= 32'h0000_0000;
         endcase
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end

   assign o_irq = |(irq_status_reg & irq_mask_reg);
   assign o_sclk = sclk_reg;
   assign o_sclk_oe = m_act;
   assign o_ss_n = ss_n_reg;
   assign o_ss_oe = m_act;
   assign o_mosi = tx_sh_reg[7];
   assign o_mosi_oe = m_act;
   assign o_miso = tx_sh_reg[7];
   assign o_miso_oe = s_act && !loop_en && (sout_en || !tx_sh_reg[7]);
endmodule
`default_nettype wire

// ### hdl/spi_xfer_defines.svh
// Constants for the serial port transfer control block.
`ifndef SPI_XFER_DEFINES_SVH
`define SPI_XFER_DEFINES_SVH
`define OFS_STATUS 8'h00
`define OFS_RX_DATA 8'h04
`define OFS_TX_DATA 8'h08
`define OFS_DIVIDER 8'h0C
`define OFS_CONTROL 8'h10
`define OFS_IRQ_MASK 8'h14
`define OFS_IRQ_STATUS 8'h18
`define CTL_RESET 16'h0000
`define DIV_RESET 8'h1B
`define CTL_THR_HI 15
`define CTL_THR_LO 14
`define CTL_TX_PURGE 13
`define CTL_RX_PURGE 12
`define CTL_CONT 11
`define CTL_LOOP 10
`define CTL_SOUT_EN 9
`define CTL_OVERWRITE 8
`define CTL_FILL_ZERO 7
`define CTL_TRIG_SEL 6
`define CTL_MASTER 1
`define CTL_ENABLE 0
`define IRQ_RX 0
`define IRQ_TX 1
`define IRQ_OVF 2
`define IRQ_UNF 3
`define FIFO_DEPTH 3'h4
`define BIT_LAST 3'h7
`define FILL_BYTE 8'h00
`endif

// ### hdl/spi_xfer_pkg.sv
// Types shared by the serial port transfer control block.
package spi_xfer_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_XFER = 3'b010,
      ST_GAP = 3'b100
   } master_state_t;
endpackage
